/* File: rtl/uhts_core.v */
// Transfer sequencing core: resume, IN status write-back, isochronous OUT.
`timescale 1ns/1ps
`include "uhts_consts.vh"
module uhts_core #(
    parameter RESUME_CYC = `UHTS_RESUME_CYC,
    parameter FRAME_CYC = `UHTS_FRAME_CYC,
    parameter PREFETCH = `UHTS_PREFETCH_BYTES
) (
    input wire core_clk,
    input wire resetn,
    input wire wakeup_pin,
    input wire hc_operational,
    input wire in_start,
    input wire iso_out_start,
    input wire [9:0] iso_out_len,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_eop,
    input wire mem_wr_ready,
    input wire mem_rd_valid,
    input wire [7:0] mem_rd_data,
    input wire tx_ready,
    output reg resume_drive,
    output reg eop_drive,
    output reg tok_valid,
    output reg [7:0] tok_pid,
    output reg mem_wr_valid,
    output reg [1:0] mem_wr_kind,
    output reg [7:0] mem_wr_data,
    output reg mem_rd_req,
    output reg tx_valid,
    output reg [7:0] tx_data,
    output reg tx_abort,
    output reg sof_pulse,
    output reg xfer_done,
    output reg [1:0] xfer_status
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg wake_s1;
    reg wake_s2;
    reg wake_s3;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            wake_s3 <= 1'b0;
        end else begin
            wake_s1 <= wakeup_pin;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
        end
    end
    wire wake_rise = wake_s2 & ~wake_s3;

    // ------------------------------------------------------------
    // Frame timer, never stalled by transfers
    // ------------------------------------------------------------
    // The frame counter has no dependence on the transfer engine, so an
    // underrun can never stop start-of-frame generation.
    reg [31:0] frame_cnt;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            frame_cnt <= 32'h00000000;
            sof_pulse <= 1'b0;
        end else begin
            sof_pulse <= 1'b0;
            if (frame_cnt >= FRAME_CYC - 1) begin
                frame_cnt <= 32'h00000000;
                sof_pulse <= 1'b1;
            end else begin
                frame_cnt <= frame_cnt + 32'h00000001;
            end
        end
    end

    // ------------------------------------------------------------
    // Resume signaling
    // ------------------------------------------------------------
    wire res_done;
    reg [1:0] eop_cnt;
    localparam integer EOP_LAST = `UHTS_EOP_CYC - 1;
    wire res_cut = resume_drive & hc_operational;
    uhts_timer #(.WIDTH(32)) u_resume_timer (
        .core_clk(core_clk),
        .resetn(resetn),
        .start(wake_rise & ~resume_drive),
        .stop(res_cut),
        .count(RESUME_CYC),
        .busy(),
        .done(res_done)
    );
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            resume_drive <= 1'b0;
            eop_drive <= 1'b0;
            eop_cnt <= 2'h0;
        end else begin
            if (wake_rise & ~resume_drive) begin
                resume_drive <= 1'b1;
            end else if (res_done | res_cut) begin
                resume_drive <= 1'b0;
                eop_drive <= 1'b1;
                eop_cnt <= EOP_LAST[1:0];
            end else if (eop_drive) begin
                if (eop_cnt == 2'h0) begin
                    eop_drive <= 1'b0;
                end else begin
                    eop_cnt <= eop_cnt - 2'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_IN_DATA = 7'h02;
    localparam [6:0] S_WR_STAT = 7'h04;
    localparam [6:0] S_WR_RETIRE = 7'h08;
    localparam [6:0] S_PREFETCH = 7'h10;
    localparam [6:0] S_OUT_DATA = 7'h20;
    localparam [6:0] S_DONE = 7'h40;

    reg [6:0] state;
    reg [9:0] byte_cnt;
    reg [9:0] out_left;
    reg [7:0] pre_buf [0:PREFETCH-1];
    reg [4:0] pre_cnt;
    reg [4:0] pre_rd;
    reg underrun;

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= S_IDLE;
            byte_cnt <= 10'h000;
            out_left <= 10'h000;
            pre_cnt <= 5'h00;
            pre_rd <= 5'h00;
            underrun <= 1'b0;
            tok_valid <= 1'b0;
            tok_pid <= 8'h00;
            mem_wr_valid <= 1'b0;
            mem_wr_kind <= 2'h0;
            mem_wr_data <= 8'h00;
            mem_rd_req <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_abort <= 1'b0;
            xfer_done <= 1'b0;
            xfer_status <= `UHTS_STAT_OK;
        end else begin
            tok_valid <= 1'b0;
            tx_abort <= 1'b0;
            xfer_done <= 1'b0;
            case (state)
            S_IDLE: begin
                byte_cnt <= 10'h000;
                underrun <= 1'b0;
                if (in_start) begin
                    tok_valid <= 1'b1;
                    tok_pid <= `UHTS_PID_IN;
                    state <= S_IN_DATA;
                end else if (iso_out_start) begin
                    out_left <= iso_out_len;
                    pre_cnt <= 5'h00;
                    pre_rd <= 5'h00;
                    mem_rd_req <= 1'b1;
                    state <= S_PREFETCH;
                end
            end
            S_IN_DATA: begin
                if (mem_wr_valid & mem_wr_ready) begin
                    mem_wr_valid <= 1'b0;
                end
                if (rx_valid) begin
                    mem_wr_valid <= 1'b1;
                    mem_wr_kind <= 2'h0;
                    mem_wr_data <= rx_data;
                    byte_cnt <= byte_cnt + 10'h001;
                end else if (rx_eop & ~(mem_wr_valid & ~mem_wr_ready)) begin
                    // A short packet ends here like any other.
                    mem_wr_valid <= 1'b1;
                    mem_wr_kind <= 2'h1;
                    mem_wr_data <= byte_cnt[7:0];
                    state <= S_WR_STAT;
                end
            end
            S_WR_STAT: begin
                // No frame boundary test here: the retire write always
                // follows the status write.
                if (mem_wr_ready) begin
                    mem_wr_kind <= 2'h2;
                    mem_wr_data <= 8'h00;
                    state <= S_WR_RETIRE;
                end
            end
            S_WR_RETIRE: begin
                if (mem_wr_ready) begin
                    mem_wr_valid <= 1'b0;
                    xfer_status <= `UHTS_STAT_OK;
                    state <= S_DONE;
                end
            end
            S_PREFETCH: begin
                if (mem_rd_valid & (pre_cnt < PREFETCH)) begin
                    pre_buf[pre_cnt[3:0]] <= mem_rd_data;
                    pre_cnt <= pre_cnt + 5'h01;
                end
                if (pre_cnt == PREFETCH) begin
                    mem_rd_req <= 1'b0;
                    tok_valid <= 1'b1;
                    tok_pid <= `UHTS_PID_OUT;
                    state <= S_OUT_DATA;
                end
            end
            S_OUT_DATA: begin
                if (tx_valid & tx_ready) begin
                    tx_valid <= 1'b0;
                end
                // The last byte is held until the link has taken it;
                // ending on the count alone would drop it on a slow link.
                if (~tx_valid | tx_ready) begin
                    if (out_left == 10'h000) begin
                        mem_rd_req <= 1'b0;
                        xfer_status <= underrun ? `UHTS_STAT_UNDERRUN :
                                                  `UHTS_STAT_OK;
                        state <= S_DONE;
                    end else if (pre_rd < PREFETCH) begin
                        tx_valid <= 1'b1;
                        tx_data <= pre_buf[pre_rd[3:0]];
                        pre_rd <= pre_rd + 5'h01;
                        out_left <= out_left - 10'h001;
                        mem_rd_req <= 1'b1;
                    end else if (mem_rd_valid) begin
                        tx_valid <= 1'b1;
                        tx_data <= mem_rd_data;
                        out_left <= out_left - 10'h001;
                    end else begin
                        // Data ran dry: end the packet, never hang.
                        tx_abort <= 1'b1;
                        tx_valid <= 1'b0;
                        mem_rd_req <= 1'b0;
                        underrun <= 1'b1;
                        xfer_status <= `UHTS_STAT_UNDERRUN;
                        state <= S_DONE;
                    end
                end
            end
            S_DONE: begin
                xfer_done <= 1'b1;
                state <= S_IDLE;
            end
            default: begin
                state <= S_IDLE;
            end
            endcase
        end
    end
endmodule

/* File: rtl/uhts_consts.vh */
// Constants for the USB host transfer sequencing block.
// Overview of operation
// - A remote wakeup seen on the downstream port starts resume signaling on that port.
// - Resume signaling is held for 20 ms before it ends.
// - Moving the host state to operational during resume cuts it short with an end-of-packet, after which software should resume the port.
// - A non-isochronous IN issues the token, accepts short packets, and writes the received bytes to memory.
// - After the IN data the status write and then the retirement write are made, in that order.
// - Both status writes are always made, whether or not a frame boundary passes.
// - Sixteen bytes are prefetched from memory before an isochronous OUT token is sent.
// - The hang on underrun during bit-stuffing, with loss of start-of-frame, is not reproduced.
`ifndef UHTS_CONSTS_VH
`define UHTS_CONSTS_VH
`define UHTS_CLK_MHZ 200
`define UHTS_RESUME_MS 20
`define UHTS_RESUME_CYC (`UHTS_RESUME_MS * 1000 * `UHTS_CLK_MHZ)
`define UHTS_FRAME_US 1
`define UHTS_FRAME_MS 1
`define UHTS_FRAME_CYC (`UHTS_FRAME_MS * 1000 * `UHTS_CLK_MHZ)
`define UHTS_PREFETCH_BYTES 16
`define UHTS_EOP_CYC 2
`define UHTS_PID_IN 8'h69
`define UHTS_PID_OUT 8'hE1
`define UHTS_PID_SOF 8'hA5
`define UHTS_STAT_OK 2'h0
`define UHTS_STAT_UNDERRUN 2'h1
`endif

/* File: rtl/uhts_timer.v */
// Down-counting timer that pulses when a loaded count expires.
`timescale 1ns/1ps
module uhts_timer #(
    parameter WIDTH = 24
) (
    input wire core_clk,
    input wire resetn,
    input wire start,
    input wire stop,
    input wire [WIDTH-1:0] count,
    output reg busy,
    output reg done
);
    reg [WIDTH-1:0] remain;

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            remain <= {WIDTH{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                remain <= count;
                busy <= 1'b1;
            end else if (stop) begin
                busy <= 1'b0;
            end else if (busy) begin
                if (remain <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

/* File: tb/uhts_checker.sv */
// Port assertions for the transfer sequencing core.
`timescale 1ns/1ps
`include "uhts_consts.vh"
module uhts_checker #(
    parameter RESUME_CYC = 50,
    parameter FRAME_CYC = 100,
    parameter PREFETCH = 16
) (
    input wire core_clk,
    input wire resetn,
    input wire wakeup_pin,
    input wire hc_operational,
    input wire iso_out_start,
    input wire mem_wr_ready,
    input wire mem_rd_valid,
    input wire mem_rd_req,
    input wire resume_drive,
    input wire eop_drive,
    input wire tok_valid,
    input wire [7:0] tok_pid,
    input wire mem_wr_valid,
    input wire [1:0] mem_wr_kind,
    input wire [7:0] mem_wr_data,
    input wire tx_abort,
    input wire sof_pulse,
    input wire xfer_done,
    input wire [1:0] xfer_status
);
reg [31:0] rcnt;
reg [31:0] fcnt;
reg [9:0] pcnt;
reg stat_done;
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        rcnt <= 32'h0;
        fcnt <= 32'h0;
        pcnt <= 10'h0;
        stat_done <= 1'b0;
    end else begin
        rcnt <= resume_drive ? rcnt + 32'h1 : 32'h0;
        fcnt <= sof_pulse ? 32'h0 : fcnt + 32'h1;
        pcnt <= iso_out_start ? 10'h0 : pcnt + {9'h0, mem_rd_valid};
        if (mem_wr_valid && mem_wr_ready)
            stat_done <= mem_wr_kind == 2'h1;
    end
end
default clocking @(posedge core_clk); endclocking
default disable iff (!resetn);
a_wake_starts_resume: assert property (
    $rose(wakeup_pin) && !resume_drive && !eop_drive && !hc_operational
    |-> ##[1:5] resume_drive) else $error("resume did not start");
a_resume_full_length: assert property (
    $fell(resume_drive) && !hc_operational |-> rcnt >= RESUME_CYC - 2
    && rcnt <= RESUME_CYC + 2) else $error("resume length wrong");
a_resume_ends_eop: assert property (
    $fell(resume_drive) |-> ##[0:1] eop_drive ##1 eop_drive ##1 !eop_drive)
    else $error("end of packet after resume wrong");
a_operational_cuts: assert property (
    resume_drive && hc_operational |-> ##[1:3] !resume_drive)
    else $error("resume not cut short");
a_write_held: assert property (
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
    && $stable(mem_wr_kind) && $stable(mem_wr_data))
    else $error("memory write dropped");
a_retire_after_status: assert property (
    mem_wr_valid && mem_wr_kind == 2'h2 |-> stat_done)
    else $error("retire write out of order");
a_retire_always: assert property (
    mem_wr_valid && mem_wr_ready && mem_wr_kind == 2'h1
    |-> ##[1:4] mem_wr_valid && mem_wr_kind == 2'h2)
    else $error("retire write skipped");
a_prefetch_first: assert property (
    tok_valid && tok_pid == `UHTS_PID_OUT |-> pcnt >= PREFETCH)
    else $error("out token before prefetch");
a_sof_keeps_running: assert property (
    fcnt <= FRAME_CYC + 1) else $error("start of frame missing");
a_abort_reports: assert property (
    tx_abort |-> ##[0:2] xfer_done && xfer_status == `UHTS_STAT_UNDERRUN)
    else $error("underrun not reported");
a_read_released: assert property (
    xfer_done |-> !mem_rd_req) else $error("memory read left requested");
c_resume_cut: cover property (resume_drive && hc_operational);
c_status_stall: cover property (mem_wr_valid && !mem_wr_ready);
c_underrun: cover property (tx_abort);
endmodule
bind uhts_core uhts_checker #(.RESUME_CYC(RESUME_CYC),
    .FRAME_CYC(FRAME_CYC), .PREFETCH(PREFETCH)) u_checker (
    .core_clk(core_clk), .resetn(resetn), .wakeup_pin(wakeup_pin),
    .hc_operational(hc_operational), .iso_out_start(iso_out_start),
    .mem_wr_ready(mem_wr_ready), .mem_rd_valid(mem_rd_valid),
    .mem_rd_req(mem_rd_req), .resume_drive(resume_drive),
    .eop_drive(eop_drive), .tok_valid(tok_valid), .tok_pid(tok_pid),
    .mem_wr_valid(mem_wr_valid), .mem_wr_kind(mem_wr_kind),
    .mem_wr_data(mem_wr_data), .tx_abort(tx_abort), .sof_pulse(sof_pulse),
    .xfer_done(xfer_done), .xfer_status(xfer_status));

/* File: tb/uhts_usb_dev.sv */
// Downstream full-speed device model facing the sequencing core.
`timescale 1ns/1ps
`include "uhts_consts.vh"
module uhts_usb_dev (
    input wire core_clk,
    input wire tok_valid,
    input wire [7:0] tok_pid,
    input wire mem_wr_valid,
    input wire tx_valid,
    input wire [3:0] in_len,
    input wire slow,
    output reg rx_valid,
    output reg [7:0] rx_data,
    output reg rx_eop,
    output reg tx_ready,
    output reg [9:0] tx_count
);
integer i;
initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_eop = 1'b0;
    tx_ready = 1'b0;
    tx_count = 10'h000;
end
always @(negedge core_clk)
    tx_ready <= slow ? ~tx_ready : 1'b1;
always @(posedge core_clk)
    if (tok_valid && tok_pid == `UHTS_PID_OUT)
        tx_count <= 10'h000;
    else if (tx_valid && tx_ready)
        tx_count <= tx_count + 10'h001;
// The core holds no receive buffer, so each byte waits for the last write.
always @(posedge core_clk)
    if (tok_valid && tok_pid == `UHTS_PID_IN) begin
        for (i = 0; i < in_len; i = i + 1) begin
            repeat (2) @(negedge core_clk);
            while (mem_wr_valid) @(negedge core_clk);
            rx_valid = 1'b1;
            rx_data = 8'hA0 + i[7:0];
            @(negedge core_clk);
            rx_valid = 1'b0;
            rx_data = ~rx_data;
        end
        repeat (2) @(negedge core_clk);
        while (mem_wr_valid) @(negedge core_clk);
        rx_eop = 1'b1;
        @(negedge core_clk);
        rx_eop = 1'b0;
    end
endmodule

/* File: tb/uhts_core_tb.sv */
// Self-checking bench for the transfer sequencing core.
`timescale 1ns/1ps
`include "uhts_consts.vh"
module uhts_core_tb;
localparam RC = 50;
localparam FC = 100;
reg core_clk = 1'b0, resetn = 1'b0, wakeup_pin = 1'b0;
reg hc_operational = 1'b0, in_start = 1'b0, iso_out_start = 1'b0;
reg mem_wr_ready = 1'b1, mem_rd_valid = 1'b0, slow = 1'b0, starve = 1'b0;
reg tx_bad = 1'b0;
reg [9:0] iso_out_len = 10'h000;
reg [7:0] mem_rd_data = 8'h00;
reg [3:0] in_len = 4'h0;
integer wstall = 0, rd_cnt = 0, cyc, failures = 0, comparisons = 0, i;
logic [9:0] wq[$];
wire rx_valid, rx_eop, tx_ready, resume_drive, eop_drive, tok_valid;
wire mem_wr_valid, mem_rd_req, tx_valid, tx_abort, sof_pulse, xfer_done;
wire [7:0] rx_data, tok_pid, mem_wr_data, tx_data;
wire [1:0] mem_wr_kind, xfer_status;
wire [9:0] tx_count;
uhts_core #(.RESUME_CYC(RC), .FRAME_CYC(FC)) DUT (.core_clk(core_clk),
    .resetn(resetn), .wakeup_pin(wakeup_pin), .in_start(in_start),
    .hc_operational(hc_operational), .iso_out_start(iso_out_start),
    .iso_out_len(iso_out_len), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_eop(rx_eop), .mem_wr_ready(mem_wr_ready), .tx_ready(tx_ready),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .resume_drive(resume_drive), .eop_drive(eop_drive),
    .tok_valid(tok_valid), .tok_pid(tok_pid), .mem_wr_valid(mem_wr_valid),
    .mem_wr_kind(mem_wr_kind), .mem_wr_data(mem_wr_data),
    .mem_rd_req(mem_rd_req), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_abort(tx_abort), .sof_pulse(sof_pulse), .xfer_done(xfer_done),
    .xfer_status(xfer_status));
uhts_usb_dev u_dev (.core_clk(core_clk), .tok_valid(tok_valid),
    .tok_pid(tok_pid), .mem_wr_valid(mem_wr_valid), .tx_valid(tx_valid),
    .in_len(in_len), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_eop(rx_eop), .tx_ready(tx_ready), .tx_count(tx_count));
always #2.5 core_clk = ~core_clk;
// Memory side; the status stall lets a frame boundary pass mid-update.
always @(negedge core_clk) begin
    mem_rd_valid <= mem_rd_req && (rd_cnt < 16 || !starve);
    mem_rd_data <= rd_cnt[7:0];
    mem_wr_ready <= !(mem_wr_valid && mem_wr_kind == 2'h1 && wstall > 0);
    if (mem_wr_valid && mem_wr_kind == 2'h1 && wstall > 0)
        wstall <= wstall - 1;
end
always @(posedge core_clk) begin
    if (mem_rd_valid && mem_rd_req)
        rd_cnt <= rd_cnt + 1;
    if (mem_wr_valid && mem_wr_ready)
        wq.push_back({mem_wr_kind, mem_wr_data});
    // Prefetched bytes were read in order, so byte n carries value n.
    if (tx_valid && tx_ready && tx_count < 10'h010 &&
        tx_data !== tx_count[7:0])
        tx_bad <= 1'b1;
end
task tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
task chk(input string w, input [15:0] e, input [15:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
        failures = failures + 1;
        $display("unexpected %s expected %h seen %h", w, e, g);
    end
endtask
function automatic bit hit(input integer s);
    case (s)
        0: hit = resume_drive === 1'b1;
        1: hit = resume_drive === 1'b0;
        2: hit = tok_valid === 1'b1;
        3: hit = xfer_done === 1'b1;
        default: hit = sof_pulse === 1'b1;
    endcase
endfunction
task wt(input integer s, input integer b);
    cyc = 0;
    while (!hit(s) && cyc < b) begin
        @(negedge core_clk);
        cyc = cyc + 1;
    end
    chk("wait done", 1, hit(s));
    if (!hit(s))
        tally_and_finish;
endtask
task t_wake(input bit cut);
    wakeup_pin = 1'b1;
    wt(0, 10);
    if (cut) begin
        repeat (10) @(negedge core_clk);
        hc_operational = 1'b1;
    end
    wt(1, RC + 10);
    chk("resume cycles", 1, cut ? cyc < 5 : cyc > RC - 4);
    @(negedge core_clk);
    chk("eop_drive", 1, eop_drive);
    hc_operational = 1'b0;
    wakeup_pin = 1'b0;
    repeat (6) @(negedge core_clk);
    $display("wake test done");
endtask
task t_in(input [3:0] len, input integer stall);
    wq.delete();
    in_len = len;
    wstall = stall;
    in_start = 1'b1;
    @(negedge core_clk);
    in_start = 1'b0;
    wt(2, 5);
    chk("tok_pid", `UHTS_PID_IN, tok_pid);
    wt(3, 500);
    chk("write count", len + 2, wq.size());
    for (i = 0; i < len; i = i + 1)
        chk("data write", {2'h0, 8'hA0 + i[7:0]}, wq[i]);
    chk("status write", {2'h1, 4'h0, len}, wq[len]);
    chk("retire kind", 2'h2, wq[len + 1][9:8]);
    $display("in test done");
endtask
task t_iso(input [9:0] len, input bit st);
    rd_cnt = 0;
    tx_bad = 1'b0;
    starve = st;
    slow = !st;
    iso_out_len = len;
    iso_out_start = 1'b1;
    @(negedge core_clk);
    iso_out_start = 1'b0;
    wt(2, 200);
    chk("tok_pid", `UHTS_PID_OUT, tok_pid);
    chk("prefetched", 1, rd_cnt >= 16);
    wt(3, 2000);
    chk("status", st ? `UHTS_STAT_UNDERRUN : `UHTS_STAT_OK,
        xfer_status);
    chk("bytes sent", st ? `UHTS_PREFETCH_BYTES : len, tx_count);
    chk("prefetch data", 0, tx_bad);
    wt(4, FC + 5);
    starve = 1'b0;
    $display("iso test done");
endtask
initial begin
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    t_wake(1'b0);
    t_wake(1'b1);
    t_in(4'h1, 0);
    t_in(4'h8, 150);
    t_iso(10'h018, 1'b0);
    t_iso(10'h028, 1'b1);
    tally_and_finish;
end
endmodule
